// >>> hw_semaphore_access_regs_test.sv
// Purpose: Self-checking bench for the host and semaphore bank pair.
// Assumes: Host status reads at 0x10 and busy ends within six cycles.
// Notes:   Rows hold master, address, write flag, data or result.
`timescale 1ns/1ps
`default_nettype none
module hw_semaphore_access_regs_test;
    import sem_pkg::*;
    typedef struct packed {
        logic [3:0] m;
        addr_t      a;
        logic [3:0] w;
        word_t      v;
    } row_s;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  sw_addr = 5'h00;
    logic        sw_wr = 1'b0;
    logic        sw_rd = 1'b0;
    word_t       sw_wdata = 32'h0;
    word_t       sw_rdata;
    word_t       rv;
    logic [31:0] sem_free;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    // Grant, queue, hand-over, flags, then each error code in turn.
    row_s rows [23] = '{
        52'h1_100_0_00000001, 52'h2_300_0_00000100, 52'h2_100_0_00000100,
        52'h2_200_1_fffffffe, 52'h1_404_0_00000001, 52'h1_100_1_00000001,
        52'h0_300_0_00000200, 52'h1_404_1_00000001, 52'h1_404_0_00000000,
        52'h1_100_1_00000001, 52'h1_500_0_00000102, 52'h1_504_1_00000000,
        52'h2_100_1_00000001, 52'h2_100_1_00000001, 52'h2_500_0_00000201,
        52'h2_504_1_00000000, 52'h2_104_0_00000001, 52'h2_104_0_00000200,
        52'h2_500_0_0000020b, 52'h2_504_1_00000000, 52'h0_204_1_00000000,
        52'h0_204_1_00000000, 52'h0_500_0_0000000c};
    sem_link_if sem_link_if_i ();
    sem_device sem_device_i (.clk_sys(clk_sys), .rst(rst),
        .link(sem_link_if_i), .sem_free(sem_free));
    sem_host sem_host_i (.clk_sys(clk_sys), .rst(rst),
        .link(sem_link_if_i), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata));
    sem_link_monitor sem_link_monitor_i (.clk_sys(clk_sys), .rst(rst),
        .req_valid(sem_link_if_i.req_valid),
        .req_write(sem_link_if_i.req_write),
        .req_addr(sem_link_if_i.req_addr),
        .rsp_valid(sem_link_if_i.rsp_valid),
        .rsp_rdata(sem_link_if_i.rsp_rdata),
        .rsp_err(sem_link_if_i.rsp_err),
        .core_irq(sem_link_if_i.core_irq),
        .err_irq(sem_link_if_i.err_irq), .sem_free(sem_free));
    // Free-running 40 MHz clock.
    always #12.5 clk_sys = ~clk_sys;
    // One strobe cycle; read data is taken in the cycle after it.
    task acc(input logic w, input logic [4:0] a, input word_t d);
        @(posedge clk_sys);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= w;
        sw_rd <= !w;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
    endtask
    // One link access; the fixed wait covers the three busy cycles.
    task op(input row_s r);
        acc(1'b1, 5'h00, {14'h0, r.m[1:0], 4'h0, r.a});
        acc(1'b1, 5'h04, r.v);
        acc(1'b1, 5'h08, {31'h0, r.w[0]});
        repeat (6) @(posedge clk_sys);
        acc(1'b0, 5'h0c, 32'h0);
    endtask
    task chk(input word_t s, input word_t e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask
    task results;
        $display("checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // A hung handshake must not stall the run for ever.
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            bad_count++;
            results();
        end
    end
    // Reset, the row table, then status marks and the read exception.
    initial begin
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        chk(sem_free, 32'hffff_ffff);
        foreach (rows[i]) begin
            op(rows[i]);
            if (!rows[i].w[0]) chk(rv, rows[i].v);
        end
        acc(1'b0, 5'h10, 32'h0);
        chk(rv & 32'h30, 32'h30);
        // Clear the marks, then re-arm the error line with junk above.
        acc(1'b1, 5'h10, 32'h3c);
        op(52'h0_00c_1_ffffff10);
        acc(1'b0, 5'h10, 32'h0);
        chk(rv & 32'h3c, 32'h20);
        op(52'h0_00c_0_00000000);
        chk(rv, 32'h0);
        acc(1'b0, 5'h10, 32'h0);
        chk(rv & 32'h2, 32'h2);
        results();
    end
endmodule // hw_semaphore_access_regs_test
`default_nettype wire

// >>> sem_defs.svh
// Purpose: Offsets, field positions, reset values and codes of the
//          semaphore block and of its host controller.
// Assumes: Byte addresses on a 12-bit link address, 32-bit data words.
// Notes:   Definitions only.
//
// Overview of operation
// - Re-arm values 0x00..0x02 re-enable core lines.
// - Re-arm value 0x10 re-enables shared error line.
// - Reading re-arm register raises read exception.
// - Re-arm bits 31-8 ignored without effect.
// - Direct read of free semaphore acquires it.
// - Granted semaphore becomes held after the access.
// - Acquiring read of held semaphore keeps holder; owner's own read records an error.
// - Owner field shows holder, zero when free.
// - Write 0 requests (granted if free, else queued); write 1 releases.
// - Granted queued request interrupts the requester.
// - Query read never alters the semaphore.
// - Window reserved bits read zero, writes ignored.
// - Per-master flag bit set on each grant.
// - Master clears its flag bit by writing one.
// - Illegal accesses record three-bit error code.
// - Query shows busy before posting indirect request.
`ifndef SEM_DEFS_SVH
`define SEM_DEFS_SVH

`define SEM_OFS_REARM      12'h00c
`define SEM_RGN_DIRECT     4'h1
`define SEM_RGN_INDIRECT   4'h2
`define SEM_RGN_QUERY      4'h3
`define SEM_RGN_FLAGS      4'h4
`define SEM_RGN_ERR        4'h5
`define SEM_OFS_ERR        12'h500
`define SEM_OFS_ERR_CLR    12'h504
`define SEM_FREE_BIT       0
`define SEM_OWNER_LSB      8
`define SEM_FREE_RST       1'b1
`define SEM_REARM_SEL_MSB  7
`define SEM_REARM_ERR      8'h10
`define SEM_ERR_NONE       3'h0
`define SEM_ERR_FREE_FREE  3'h1
`define SEM_ERR_NOT_OWNER  3'h2
`define SEM_ERR_OWNED      3'h3
`define SEM_ERR_PENDING    3'h4
`define SEM_NUM_SEM        32
`define SEM_NUM_MASTER     3

`define HOST_OFS_TARGET    5'h00
`define HOST_OFS_WDATA     5'h04
`define HOST_OFS_GO        5'h08
`define HOST_OFS_RDATA     5'h0c
`define HOST_OFS_STATUS    5'h10
`define HOST_TGT_MID_LSB   16
`define HOST_ST_BUSY       0
`define HOST_ST_EXC        1
`define HOST_ST_CORE_LSB   2
`define HOST_ST_ERR        5

`endif

// >>> sem_device.sv
// Purpose: Hardware semaphore bank shared by several masters.
// Assumes: The link carries one request at a time; answers come one
//          cycle after the request.
// Notes:   Master identifier doubles as owner code, so master 0 and a
//          free semaphore both show owner zero; FREE tells them apart.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "sem_defs.svh"
module sem_device #(
    parameter int NSEM = `SEM_NUM_SEM,
    parameter int NM   = `SEM_NUM_MASTER
) (
    input  wire logic     clk_sys,   // System clock.
    input  wire logic     rst,       // Asynchronous reset, active high.
    sem_link_if.dev       link,      // Link toward the masters.
    output logic [NSEM-1:0] sem_free // Free state of each semaphore.
);
    import sem_pkg::*;
    localparam int SW = $clog2(NSEM);

    logic [NSEM-1:0] free_q;
    mid_t            owner_q [NSEM];
    logic [NSEM-1:0] flag_q  [NM];
    logic [NM-1:0]   pend_q;
    logic [NM-1:0]   core_pend_q;
    logic [NM-1:0]   core_arm_q;
    logic            err_pend_q;
    logic            err_arm_q;
    logic [2:0]      err_code_q;
    mid_t            err_mid_q;
    logic [SW-1:0]   err_sem_q;

    mid_t            q_head  [NSEM];
    logic [NSEM-1:0] q_empty;

    // Request decode.
    logic          rd;
    logic          wr;
    logic          win;
    logic          rel;
    logic          post;
    logic          acq;
    logic [SW-1:0] s;
    mid_t          mid;
    logic          held;
    logic          own;
    logic [2:0]    err_d;
    logic          take_acq;
    logic          take_post;
    logic          do_push;
    logic          do_rel;
    logic          handoff;
    logic [NM-1:0] core_ev;
    logic          rearm_wr;
    logic [NM-1:0] flag_clr_sel;
    word_t         rdata_d;

    assign rd  = link.req_valid & ~link.req_write;
    assign wr  = link.req_valid & link.req_write;
    assign s   = link.req_addr[SW+1:2];
    assign mid = link.req_mid;
    assign win = (link.req_addr[11:8] == `SEM_RGN_DIRECT
               || link.req_addr[11:8] == `SEM_RGN_INDIRECT
               || link.req_addr[11:8] == `SEM_RGN_QUERY)
               && !link.req_addr[7] && link.req_addr[1:0] == 2'h0;
    assign held     = ~free_q[s];
    assign own      = (owner_q[s] == mid);
    assign acq      = rd & win & (link.req_addr[11:8] == `SEM_RGN_DIRECT);
    assign rel      = wr & win & link.req_wdata[`SEM_FREE_BIT];
    assign post     = wr & win & ~link.req_wdata[`SEM_FREE_BIT];
    assign rearm_wr = wr & (link.req_addr == `SEM_OFS_REARM);

    // Error classification of the current access.
    always_comb begin
        err_d = `SEM_ERR_NONE;
        if (rel && !held) begin
            err_d = `SEM_ERR_FREE_FREE;
        end else if (rel && !own) begin
            err_d = `SEM_ERR_NOT_OWNER;
        end else if (post && pend_q[mid]) begin
            err_d = `SEM_ERR_PENDING;
        end else if ((acq || post) && held && own) begin
            err_d = `SEM_ERR_OWNED;
        end
    end

    // A held semaphore read through the direct window is left alone.
    assign take_acq  = acq & ~held;
    assign take_post = post & ~held & (err_d == `SEM_ERR_NONE);
    assign do_push   = post & held & (err_d == `SEM_ERR_NONE);
    assign do_rel    = rel & (err_d == `SEM_ERR_NONE);
    assign handoff   = do_rel & ~q_empty[s];

    // Per-semaphore queues keep requesters in arrival order.
    for (genvar g = 0; g < NSEM; g++) begin : g_queue
        sem_fifo #(.W(2), .DEPTH(NM)) u_queue (
            .clk_sys (clk_sys),
            .rst     (rst),
            .push    (do_push && s == SW'(g)),
            .pop     (handoff && s == SW'(g)),
            .din     (mid),
            .dout    (q_head[g]),
            .empty   (q_empty[g])
        );
    end

    // Free and owner state; only grants and releases touch it.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            free_q <= {NSEM{`SEM_FREE_RST}};
            for (int i = 0; i < NSEM; i++) begin
                owner_q[i] <= '0;
            end
        end else if (take_acq || take_post) begin
            free_q[s]  <= 1'b0;
            owner_q[s] <= mid;
        end else if (handoff) begin
            owner_q[s] <= q_head[s];
        end else if (do_rel) begin
            free_q[s]  <= 1'b1;
            owner_q[s] <= '0;
        end
    end

    // Holding flags: set on grant, cleared by writing ones; set wins.
    always_comb begin
        for (int m = 0; m < NM; m++) begin
            flag_clr_sel[m] = wr && link.req_addr[11:8] == `SEM_RGN_FLAGS
                && link.req_addr[7:0] == 8'(m * 4);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int m = 0; m < NM; m++) begin
                flag_q[m] <= '0;
            end
        end else begin
            for (int m = 0; m < NM; m++) begin
                if (flag_clr_sel[m]) begin
                    flag_q[m] <= flag_q[m] & ~link.req_wdata[NSEM-1:0];
                end
                if (((take_acq || take_post) && mid == 2'(m))
                    || (handoff && q_head[s] == 2'(m))) begin
                    flag_q[m][s] <= 1'b1;
                end
            end
        end
    end

    // One outstanding queued request per master.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pend_q <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                if (handoff && q_head[s] == 2'(m)) begin
                    pend_q[m] <= 1'b0;
                end
                if (do_push && mid == 2'(m)) begin
                    pend_q[m] <= 1'b1;
                end
            end
        end
    end

    // Grant events for the indirect path, per master.
    always_comb begin
        for (int m = 0; m < NM; m++) begin
            core_ev[m] = (take_post && mid == 2'(m))
                      || (handoff && q_head[s] == 2'(m));
        end
    end

    // Core lines: an event waits while the line is disarmed; firing
    // disarms it until software writes the matching re-arm value.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            core_pend_q   <= '0;
            core_arm_q    <= '1;
            link.core_irq <= '0;
        end else begin
            for (int m = 0; m < NM; m++) begin
                link.core_irq[m] <= core_pend_q[m] & core_arm_q[m];
                core_pend_q[m]   <= (core_pend_q[m] & ~core_arm_q[m])
                                  | core_ev[m];
                if (core_pend_q[m] && core_arm_q[m]) begin
                    core_arm_q[m] <= 1'b0;
                end
                if (rearm_wr && link.req_wdata[`SEM_REARM_SEL_MSB:0]
                                == 8'(m)) begin
                    core_arm_q[m] <= 1'b1;
                end
            end
        end
    end

    // Shared error line, handled like a core line.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err_pend_q   <= 1'b0;
            err_arm_q    <= 1'b1;
            link.err_irq <= 1'b0;
        end else begin
            link.err_irq <= err_pend_q & err_arm_q;
            err_pend_q   <= (err_pend_q & ~err_arm_q)
                          | (err_d != `SEM_ERR_NONE);
            if (err_pend_q && err_arm_q) begin
                err_arm_q <= 1'b0;
            end
            if (rearm_wr && link.req_wdata[`SEM_REARM_SEL_MSB:0]
                            == `SEM_REARM_ERR) begin
                err_arm_q <= 1'b1;
            end
        end
    end

    // Error record; a new error wins over a clear in the same cycle.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            err_code_q <= `SEM_ERR_NONE;
            err_mid_q  <= '0;
            err_sem_q  <= '0;
        end else if (err_d != `SEM_ERR_NONE) begin
            err_code_q <= err_d;
            err_mid_q  <= mid;
            err_sem_q  <= s;
        end else if (wr && link.req_addr == `SEM_OFS_ERR_CLR) begin
            err_code_q <= `SEM_ERR_NONE;
            err_mid_q  <= '0;
            err_sem_q  <= '0;
        end
    end

    // Read data reflects state before the access, so a granting read
    // returns FREE = 1 and the hold takes effect after it.
    always_comb begin
        rdata_d = '0;
        if (win) begin
            rdata_d[`SEM_FREE_BIT] = free_q[s];
            if (held) begin
                rdata_d[`SEM_OWNER_LSB+7:`SEM_OWNER_LSB] =
                    8'(owner_q[s]);
            end
        end else if (link.req_addr[11:8] == `SEM_RGN_FLAGS) begin
            for (int m = 0; m < NM; m++) begin
                if (link.req_addr[7:0] == 8'(m * 4)) begin
                    rdata_d[NSEM-1:0] = flag_q[m];
                end
            end
        end else if (link.req_addr == `SEM_OFS_ERR) begin
            rdata_d[15:0] = {6'h0, err_mid_q, 5'(err_sem_q),
                             err_code_q};
        end
    end

    // Answer one cycle after every request; the re-arm register is
    // write-only and a read of it answers with an exception.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            link.rsp_valid <= 1'b0;
            link.rsp_rdata <= '0;
            link.rsp_err   <= 1'b0;
        end else begin
            link.rsp_valid <= link.req_valid;
            link.rsp_rdata <= rd ? rdata_d : '0;
            link.rsp_err   <= rd && link.req_addr == `SEM_OFS_REARM;
        end
    end

    // Mirror of the free state for observation.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sem_free <= {NSEM{`SEM_FREE_RST}};
        end else begin
            sem_free <= free_q;
        end
    end
endmodule // sem_device
`default_nettype wire

// >>> sem_fifo.sv
// Purpose: Small request queue of master identifiers for one semaphore.
// Assumes: Caller never pushes when full nor pops when empty.
// Notes:   Depth equal to the master count suffices, since each master
//          may have only one request pending.
`timescale 1ns/1ps
`default_nettype none
module sem_fifo #(
    parameter int W     = 2,
    parameter int DEPTH = 3
) (
    input  wire logic         clk_sys, // System clock.
    input  wire logic         rst,     // Asynchronous reset, active high.
    input  wire logic         push,    // Append din at the tail.
    input  wire logic         pop,     // Drop the head entry.
    input  wire logic [W-1:0] din,     // Entry to append.
    output logic      [W-1:0] dout,    // Head entry.
    output logic              empty    // No entry held.
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [W-1:0]  mem_q [DEPTH];
    logic [PW-1:0] rd_q;
    logic [PW-1:0] wr_q;
    logic [PW:0]   cnt_q;

    // Storage is written only at the tail slot.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= din;
        end
    end

    // Pointers wrap at DEPTH, which need not be a power of two.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rd_q  <= '0;
            wr_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    assign dout  = mem_q[rd_q];
    assign empty = (cnt_q == '0);
endmodule // sem_fifo
`default_nettype wire

// >>> sem_host.sv
// Purpose: Master-side engine that turns software orders into link
//          accesses and reports answers and interrupts.
// Assumes: Software follows the plain register port protocol.
// Notes:   Software must release what it holds, clear its flag bits,
//          check the query window before posting, and re-arm lines.
`timescale 1ns/1ps
`default_nettype none
`include "sem_defs.svh"
module sem_host (
    input  wire logic         clk_sys,  // System clock.
    input  wire logic         rst,      // Asynchronous reset, active high.
    sem_link_if.host          link,     // Link toward the semaphores.
    input  wire logic [4:0]   sw_addr,  // Register byte address.
    input  wire logic [31:0]  sw_wdata, // Write data.
    input  wire logic         sw_wr,    // Write strobe.
    input  wire logic         sw_rd,    // Read strobe.
    output logic      [31:0]  sw_rdata  // Read data, one cycle later.
);
    import sem_pkg::*;

    host_state_e state_q;
    addr_t       tgt_addr_q;
    mid_t        tgt_mid_q;
    word_t       wdata_q;
    logic        go_write_q;
    word_t       rdata_q;
    logic        exc_q;
    logic [2:0]  core_seen_q;
    logic        err_seen_q;
    logic        go;

    // A launch while busy is dropped; software polls the busy bit.
    assign go = sw_wr && sw_addr == `HOST_OFS_GO && state_q == HOST_IDLE;

    // Target, data and direction of the next access.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tgt_addr_q <= '0;
            tgt_mid_q  <= '0;
            wdata_q    <= '0;
            go_write_q <= 1'b0;
        end else begin
            if (sw_wr && sw_addr == `HOST_OFS_TARGET) begin
                tgt_addr_q <= sw_wdata[11:0];
                tgt_mid_q  <= sw_wdata[`HOST_TGT_MID_LSB+1:`HOST_TGT_MID_LSB];
            end
            if (sw_wr && sw_addr == `HOST_OFS_WDATA) begin
                wdata_q <= sw_wdata;
            end
            if (go) begin
                go_write_q <= sw_wdata[0];
            end
        end
    end

    // Access sequencer: one request strobe, then wait for the answer.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q        <= HOST_IDLE;
            link.req_valid <= 1'b0;
            link.req_write <= 1'b0;
            link.req_mid   <= '0;
            link.req_addr  <= '0;
            link.req_wdata <= '0;
        end else begin
            link.req_valid <= 1'b0;
            case (state_q)
                HOST_IDLE: begin
                    if (go) begin
                        state_q <= HOST_ISSUE;
                    end
                end
                HOST_ISSUE: begin
                    link.req_valid <= 1'b1;
                    link.req_write <= go_write_q;
                    link.req_mid   <= tgt_mid_q;
                    link.req_addr  <= tgt_addr_q;
                    link.req_wdata <= wdata_q;
                    state_q        <= HOST_WAIT;
                end
                HOST_WAIT: begin
                    if (link.rsp_valid) begin
                        state_q <= HOST_IDLE;
                    end
                end
                default: begin
                    state_q <= HOST_IDLE;
                end
            endcase
        end
    end

    // Answer capture and sticky interrupt record; events win over clears.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q     <= '0;
            exc_q       <= 1'b0;
            core_seen_q <= '0;
            err_seen_q  <= 1'b0;
        end else begin
            if (link.rsp_valid) begin
                rdata_q <= link.rsp_rdata;
                exc_q   <= link.rsp_err;
            end
            // A clear and a new pulse in one cycle keep the new pulse.
            if (sw_wr && sw_addr == `HOST_OFS_STATUS) begin
                core_seen_q <= (core_seen_q & ~sw_wdata[4:2])
                             | link.core_irq;
                err_seen_q  <= (err_seen_q & ~sw_wdata[5]) | link.err_irq;
            end else begin
                core_seen_q <= core_seen_q | link.core_irq;
                err_seen_q  <= err_seen_q | link.err_irq;
            end
        end
    end

    // Register read port: data stand in the cycle after the strobe.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_rdata <= '0;
        end else if (sw_rd) begin
            case (sw_addr)
                `HOST_OFS_TARGET: sw_rdata <= {14'h0, tgt_mid_q, 4'h0,
                                               tgt_addr_q};
                `HOST_OFS_WDATA:  sw_rdata <= wdata_q;
                `HOST_OFS_RDATA:  sw_rdata <= rdata_q;
                `HOST_OFS_STATUS: sw_rdata <= {26'h0, err_seen_q,
                    core_seen_q, exc_q, state_q != HOST_IDLE};
                default:          sw_rdata <= '0;
            endcase
        end else begin
            sw_rdata <= '0;
        end
    end
endmodule // sem_host
`default_nettype wire

// >>> sem_link_if.sv
// Purpose: Shared memory-mapped link between a master and the semaphores.
// Assumes: One request at a time; answer follows one cycle later.
// Notes:   No clocking block; both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface sem_link_if;
    logic                 req_valid;  // One-cycle request strobe.
    logic                 req_write;  // High for write, low for read.
    sem_pkg::mid_t        req_mid;    // Identifier of the issuing master.
    sem_pkg::addr_t       req_addr;   // Byte address of the register.
    sem_pkg::word_t       req_wdata;  // Write data.
    logic                 rsp_valid;  // One-cycle answer strobe.
    sem_pkg::word_t       rsp_rdata;  // Read data beside rsp_valid.
    logic                 rsp_err;    // Read exception beside rsp_valid.
    logic [2:0]           core_irq;   // One-cycle grant interrupt per core.
    logic                 err_irq;    // One-cycle shared error interrupt.

    modport dev  (input req_valid, req_write, req_mid, req_addr, req_wdata,
                  output rsp_valid, rsp_rdata, rsp_err, core_irq, err_irq);
    modport host (output req_valid, req_write, req_mid, req_addr, req_wdata,
                  input rsp_valid, rsp_rdata, rsp_err, core_irq, err_irq);
endinterface
`default_nettype wire

// >>> sem_link_monitor.sv
// Purpose: Assertions on the link between host and semaphore bank.
// Assumes: One request at a time, answered one cycle later.
// Notes:   Instantiated beside the link in the bench top.
`timescale 1ns/1ps
`default_nettype none
`include "sem_defs.svh"
module sem_link_monitor (
    input wire logic           clk_sys,   // Clock.
    input wire logic           rst,       // Reset.
    input wire logic           req_valid, // Request.
    input wire logic           req_write, // Write.
    input wire sem_pkg::addr_t req_addr,  // Address.
    input wire logic           rsp_valid, // Answer.
    input wire sem_pkg::word_t rsp_rdata, // Read data.
    input wire logic           rsp_err,   // Exception.
    input wire logic [2:0]     core_irq,  // Core lines.
    input wire logic           err_irq,   // Error line.
    input wire logic [31:0]    sem_free   // Free map.
);
    wire logic [4:0] sel = req_addr[6:2];
    // One domain, so the clock and the reset are named once.
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Reads of one window region, or of any window.
    sequence s_rd(logic [3:0] r);
        req_valid && !req_write && req_addr[11:8] == r;
    endsequence
    sequence s_win;
        req_valid && !req_write && req_addr[11:8] inside {[4'h1:4'h3]};
    endsequence
    a_answer_next: assert property (req_valid |=> rsp_valid)
        else $error("request not answered");
    a_answer_cause: assert property (rsp_valid |-> $past(req_valid))
        else $error("answer without request");
    a_rearm_exc: assert property (req_valid && !req_write &&
        req_addr == `SEM_OFS_REARM |=> rsp_err && rsp_rdata == 32'h0)
        else $error("rearm read gave data");
    a_exc_cause: assert property (rsp_err |->
        $past(req_addr) == `SEM_OFS_REARM) else $error("stray exception");
    a_resv_zero: assert property (s_win |=>
        rsp_rdata[31:16] == 16'h0 && rsp_rdata[7:1] == 7'h0)
        else $error("reserved bits set");
    a_owner_free: assert property (s_win |=>
        rsp_rdata[0] -> rsp_rdata[15:8] == 8'h0) else $error("free owner");
    a_query_keep: assert property (s_rd(`SEM_RGN_QUERY) |=>
        $stable(sem_free) && rsp_rdata[0] == $past(sem_free[sel]))
        else $error("query changed state");
    // The free mirror lags the hold by one more cycle than the answer.
    a_direct_grant: assert property (s_rd(`SEM_RGN_DIRECT) ##0
        sem_free[sel] |=> rsp_rdata[0] ##1 !sem_free[$past(sel, 2)])
        else $error("free semaphore not granted");
    a_held_keep: assert property (s_rd(`SEM_RGN_DIRECT) ##0
        !sem_free[sel] |=> !rsp_rdata[0] && $stable(sem_free))
        else $error("held semaphore changed");
    a_irq_cause: assert property (core_irq != 3'h0 || err_irq
        |-> $past(rsp_valid)) else $error("interrupt without access");
endmodule // sem_link_monitor
`default_nettype wire

// >>> sem_pkg.sv
// Purpose: Shared types of the semaphore block and its host controller.
// Assumes: Master identifiers are two bits wide.
// Notes:   Constants live in sem_defs.svh.
package sem_pkg;
    typedef logic [1:0]  mid_t;
    typedef logic [11:0] addr_t;
    typedef logic [31:0] word_t;
    typedef enum logic [2:0] {
        HOST_IDLE  = 3'b001,
        HOST_ISSUE = 3'b010,
        HOST_WAIT  = 3'b100
    } host_state_e;
endpackage
